// File: pkg/spcg_map.svh
// Register map, field positions and reset values of the unit clock gating block
// Summary of operation
// - A cleared gating bit withholds the clock of its unit, leaving it stopped.
// - A set gating bit delivers the system clock to its unit.
// - Any access to a unit whose clock is gated off ends in a bus fault.
// - After reset every gating bit reads zero and all units are unclocked.
// - Bits 18, 17 and 16 gate timers two, one and zero and are read-write.
// - Bit 12 is a read-write gate for two-wire bus unit zero.
// - Bit 4 is a read-write gate for synchronous serial unit zero.
// - Bits 1 and 0 are read-write gates for asynchronous serial units one and zero.
// - Bits 15:13, 11:5 and 3:2 are read-only zero and software preserves them.
// - Run gating applies while running, sleep gating in sleep, deep-sleep gating in deep sleep.
// - Sleep and deep-sleep gating apply only when auto clock gating is selected.
// - The deep-sleep gating register sits at offset 0x124 and resets to zero.
// - Bits 26, 25 and 24 gate comparators two, one and zero; 31:27 and 23:19 read zero.
`ifndef SPCG_MAP_SVH
`define SPCG_MAP_SVH
`define SPCG_OFS_RUN 12'h104
`define SPCG_OFS_SLEEP 12'h114
`define SPCG_OFS_DEEP 12'h124
`define SPCG_OFS_CFG 12'h130
`define SPCG_OFS_IRQ_STAT 12'h134
`define SPCG_OFS_IRQ_MASK 12'h138
`define SPCG_GATE_MASK 32'h0707_1013
`define SPCG_GATE_RESET 32'h0000_0000
`define SPCG_IRQ_MASK 32'h0000_0001
`define SPCG_UNIT_COUNT 10
`define SPCG_BIT_ASYNC_SERIAL_ZERO_GATE 0
`define SPCG_BIT_ASYNC_SERIAL_ONE_GATE 1
`define SPCG_BIT_SSI 4
`define SPCG_BIT_I2C 12
`define SPCG_BIT_TMR0 16
`define SPCG_BIT_TMR1 17
`define SPCG_BIT_TMR2 18
`define SPCG_BIT_CMP0 24
`define SPCG_BIT_CMP1 25
`define SPCG_BIT_CMP2 26
`endif

// File: pkg/spcg_pkg.sv
// Types of the unit clock gating block
package spcg_pkg;
    typedef enum logic [1:0] {
        PwrRun,
        PwrSleep,
        PwrDeep
    } spcg_mode_t;
    typedef enum logic [0:0] {
        BusIdle,
        BusAck
    } spcg_bus_t;
    typedef struct packed {
        logic [31:0] runGates;
        logic [31:0] sleepGates;
        logic [31:0] deepGates;
        logic autoGate;
        logic faultStat;
        logic faultMask;
        spcg_bus_t bus;
        logic ack;
        logic err;
        logic [31:0] rdat;
        logic [9:0] gates;
    } spcg_state_t;
endpackage : spcg_pkg

// File: src/spcg_gate_cell.sv
// Glitch-free clock gate cell for one peripheral unit
`timescale 1ns/1ns
module spcg_gate_cell (
    input wire logic mclk,
    input wire logic enable,
    output logic gatedClk
);
    logic latchEn;
    // Latch open while clock low, so enable changes never chop a high phase
    always_latch begin
        if (!mclk) begin
            latchEn = enable;
        end
    end
    assign gatedClk = mclk & latchEn;
endmodule : spcg_gate_cell

// File: src/spcg_clock_gating.sv
// Unit clock gating with Wishbone registers and gated-unit bus fault
`timescale 1ns/1ns
`include "spcg_map.svh"
module spcg_clock_gating #(
    parameter int UNITS = `SPCG_UNIT_COUNT
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic sleepReq,
    input wire logic deepSleepReq,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic [UNITS-1:0] unitAccess,
    output logic [UNITS-1:0] unitFault,
    output logic [UNITS-1:0] unitClk,
    output logic [UNITS-1:0] unitClkEn,
    output logic irq
);
    spcg_pkg::spcg_state_t st_r;
    spcg_pkg::spcg_state_t st_nxt;
    spcg_pkg::spcg_mode_t mode;
    logic [31:0] applied;
    logic [UNITS-1:0] faultNow;
    logic req;

    localparam int BitPos [0:9] = '{`SPCG_BIT_ASYNC_SERIAL_ZERO_GATE, `SPCG_BIT_ASYNC_SERIAL_ONE_GATE, `SPCG_BIT_SSI,
        `SPCG_BIT_I2C, `SPCG_BIT_TMR0, `SPCG_BIT_TMR1, `SPCG_BIT_TMR2,
        `SPCG_BIT_CMP0, `SPCG_BIT_CMP1, `SPCG_BIT_CMP2};

    // Writable bits only; reserved bits drop on write
    function automatic logic [31:0] gateWrite(input logic [31:0] old, input logic [31:0] d,
            input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r & `SPCG_GATE_MASK;
    endfunction : gateWrite

    always_comb begin
        mode = spcg_pkg::PwrRun;
        if (deepSleepReq) begin
            mode = spcg_pkg::PwrDeep;
        end else if (sleepReq) begin
            mode = spcg_pkg::PwrSleep;
        end
    end

    // Mode picks the gating set; without auto gating sleep keeps run set
    always_comb begin
        applied = st_r.runGates;
        if (st_r.autoGate) begin
            case (mode)
                spcg_pkg::PwrSleep: applied = st_r.sleepGates;
                spcg_pkg::PwrDeep: applied = st_r.deepGates;
                default: applied = st_r.runGates;
            endcase
        end
    end

    assign req = wb_cyc_i & wb_stb_i;

    generate
        for (genvar u = 0; u < UNITS; u++) begin : g_unit
            assign faultNow[u] = unitAccess[u] & ~st_r.gates[u];
            spcg_gate_cell u_gate (
                .mclk(mclk),
                .enable(st_r.gates[u] & clkEn),
                .gatedClk(unitClk[u])
            );
        end
    endgenerate

    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        st_nxt.err = 1'b0;
        for (int u = 0; u < UNITS; u++) begin
            st_nxt.gates[u] = applied[BitPos[u]];
        end
        if (|faultNow) begin
            st_nxt.faultStat = 1'b1;
        end
        case (st_r.bus)
            spcg_pkg::BusIdle: begin
                if (req) begin
                    st_nxt.bus = spcg_pkg::BusAck;
                    st_nxt.ack = 1'b1;
                    st_nxt.rdat = 32'h0000_0000;
                    case (wb_adr_i)
                        `SPCG_OFS_RUN: begin
                            st_nxt.rdat = st_r.runGates;
                            if (wb_we_i) begin
                                st_nxt.runGates = gateWrite(st_r.runGates, wb_dat_i, wb_sel_i);
                            end
                        end
                        `SPCG_OFS_SLEEP: begin
                            st_nxt.rdat = st_r.sleepGates;
                            if (wb_we_i) begin
                                st_nxt.sleepGates = gateWrite(st_r.sleepGates, wb_dat_i,
                                    wb_sel_i);
                            end
                        end
                        `SPCG_OFS_DEEP: begin
                            st_nxt.rdat = st_r.deepGates;
                            if (wb_we_i) begin
                                st_nxt.deepGates = gateWrite(st_r.deepGates, wb_dat_i,
                                    wb_sel_i);
                            end
                        end
                        `SPCG_OFS_CFG: begin
                            st_nxt.rdat = {31'h0000_0000, st_r.autoGate};
                            if (wb_we_i && wb_sel_i[0]) begin
                                st_nxt.autoGate = wb_dat_i[0];
                            end
                        end
                        `SPCG_OFS_IRQ_STAT: begin
                            st_nxt.rdat = {31'h0000_0000, st_r.faultStat};
                            // New fault in the same cycle wins over the clear
                            if (wb_we_i && wb_sel_i[0] && wb_dat_i[0] && !(|faultNow)) begin
                                st_nxt.faultStat = 1'b0;
                            end
                        end
                        `SPCG_OFS_IRQ_MASK: begin
                            st_nxt.rdat = {31'h0000_0000, st_r.faultMask};
                            if (wb_we_i && wb_sel_i[0]) begin
                                st_nxt.faultMask = wb_dat_i[0];
                            end
                        end
                        default: begin
                            st_nxt.ack = 1'b0;
                            st_nxt.err = 1'b1;
                        end
                    endcase
                end
            end
            spcg_pkg::BusAck: begin
                st_nxt.bus = spcg_pkg::BusIdle;
            end
            default: st_nxt.bus = spcg_pkg::BusIdle;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_r <= '0;
            st_r.bus <= spcg_pkg::BusIdle;
        end else if (clkEn) begin
            st_r <= st_nxt;
        end
    end

    assign wb_dat_o = st_r.rdat;
    assign wb_ack_o = st_r.ack;
    assign wb_err_o = st_r.err;
    assign unitFault = faultNow;
    assign unitClkEn = st_r.gates;
    assign irq = st_r.faultStat & st_r.faultMask;

    // Helper: register write at given offset lands at this edge
    logic wrLand;
    assign wrLand = req & wb_we_i & (st_r.bus == spcg_pkg::BusIdle) & clkEn;

    a_reset_zero: assert property (@(posedge mclk)
        !reset_n |=> (st_r.deepGates == `SPCG_GATE_RESET) && (st_r.sleepGates == `SPCG_GATE_RESET))
        else $error("Gating registers not zero after reset");
    a_gated_fault: assert property (@(posedge mclk) disable iff (!reset_n)
        (unitAccess[0] && !st_r.gates[0]) |-> unitFault[0])
        else $error("Access to stopped unit without fault");
    a_open_nofault: assert property (@(posedge mclk) disable iff (!reset_n)
        st_r.gates[0] |-> !unitFault[0])
        else $error("Fault raised on clocked unit");
    a_reserved_zero: assert property (@(posedge mclk) disable iff (!reset_n)
        ((st_r.sleepGates | st_r.deepGates | st_r.runGates) & ~`SPCG_GATE_MASK) == 32'h0)
        else $error("Reserved gating bit set");
    a_deep_write: assert property (@(posedge mclk) disable iff (!reset_n)
        (wrLand && wb_adr_i == `SPCG_OFS_DEEP && wb_sel_i == 4'hf)
        |=> st_r.deepGates == ($past(wb_dat_i) & `SPCG_GATE_MASK))
        else $error("Deep-sleep register write lost");
    a_sleep_apply: assert property (@(posedge mclk) disable iff (!reset_n)
        (clkEn && st_r.autoGate && sleepReq && !deepSleepReq) |=>
        !clkEn || st_r.gates[4] == $past(st_r.sleepGates[`SPCG_BIT_TMR0]))
        else $error("Sleep gating not applied");
    a_noauto_run: assert property (@(posedge mclk) disable iff (!reset_n)
        (clkEn && !st_r.autoGate) |=> !clkEn || st_r.gates[3] == $past(st_r.runGates[`SPCG_BIT_I2C]))
        else $error("Run gating not kept without auto gating");
    a_deep_apply: assert property (@(posedge mclk) disable iff (!reset_n)
        (clkEn && st_r.autoGate && deepSleepReq) |=>
        !clkEn || st_r.gates[9] == $past(st_r.deepGates[`SPCG_BIT_CMP2]))
        else $error("Deep-sleep gating not applied");
    // Gate latch is transparent in the low phase, so before each edge it holds the enable
    a_clock_stop: assert property (@(posedge mclk) disable iff (!reset_n)
        g_unit[1].u_gate.latchEn == (st_r.gates[1] & clkEn))
        else $error("Clock gate of unit one disagrees with its gating bit");
endmodule : spcg_clock_gating

// File: tb/spcg_unit_model.sv
// Gated peripheral units: count their clock edges and raise bus accesses
`timescale 1ns/1ns
module spcg_unit_model (
    input wire logic [9:0] unitClk,
    input wire logic [9:0] accReq,
    output logic [9:0] unitAccess,
    output logic [79:0] ticks
);
    // Decoded bus access simply reaches the addressed unit
    assign unitAccess = accReq;
    initial ticks = 80'h0;
    for (genvar u = 0; u < 10; u++) begin : g_unit
        // A unit only advances while its clock is delivered
        always @(posedge unitClk[u]) begin
            ticks[u*8+:8] <= ticks[u*8+:8] + 8'h01;
        end
    end
endmodule : spcg_unit_model

// File: tb/spcg_clock_gating_tb.sv
// Self-checking bench of the unit clock gating block
`timescale 1ns/1ns
`include "spcg_map.svh"
module spcg_clock_gating_tb;
    logic mclk, reset_n, cyc, stb, we, ack, err, irq, sleepQ, deepQ, e;
    logic [11:0] adr;
    logic [31:0] dat, rdat, q, x, v;
    logic [31:0] g [3];
    logic [11:0] ofs [3] = '{`SPCG_OFS_RUN, `SPCG_OFS_SLEEP, `SPCG_OFS_DEEP};
    logic [9:0] accReq, unitAccess, unitFault, unitClk, unitClkEn, aq, runv;
    logic [79:0] ticks, t0;
    int err_total = 0;
    int samples_checked = 0;
    spcg_clock_gating i_dut (.mclk(mclk), .reset_n(reset_n), .clkEn(1'b1),
        .sleepReq(sleepQ), .deepSleepReq(deepQ), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .wb_err_o(err), .unitAccess(unitAccess), .unitFault(unitFault),
        .unitClk(unitClk), .unitClkEn(unitClkEn), .irq(irq));
    spcg_unit_model i_units (.unitClk(unitClk), .accReq(accReq), .unitAccess(unitAccess),
        .ticks(ticks));
    always #20 mclk = ~mclk;
    function automatic logic [31:0] comp(logic [31:0] v);
        comp = {22'h0, v[26], v[25], v[24], v[18], v[17], v[16], v[12], v[4], v[1], v[0]};
    endfunction : comp
    task automatic chk(string n, logic [31:0] ex, logic [31:0] s);
        samples_checked++;
        if (ex !== s) begin
            $display("CHECK FAILED %s expected %h seen %h", n, ex, s);
            err_total++;
        end
    endtask : chk
    task automatic wbx(logic w, logic [11:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        // Look just after each edge: the answer seen here is what the next edge samples
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        q = rdat;
        e = err;
        @(posedge mclk);
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) err_total++;
    endtask : wbx
    task automatic end_sim;
        if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    initial begin
        // Generous bound: all transfers answer within two cycles
        repeat (20000) @(posedge mclk);
        err_total++;
        end_sim();
    end
    initial begin
        mclk = 0; reset_n = 0; cyc = 0; stb = 0; we = 0; adr = 0; dat = 0;
        sleepQ = 0; deepQ = 0; accReq = 0;
        v = $urandom(32'h14e6);
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        foreach (ofs[i]) begin
            wbx(1'b0, ofs[i], 32'h0);
            chk("reset gates", `SPCG_GATE_RESET, q);
        end
        chk("clocks after reset", 32'h0, {22'h0, unitClkEn});
        wbx(1'b0, 12'h200, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, e});
        for (int a = 0; a < 2; a++) begin
            for (int m = 0; m < 4; m++) begin
                wbx(1'b1, `SPCG_OFS_CFG, 32'(a));
                wbx(1'b1, `SPCG_OFS_IRQ_MASK, 32'(a));
                wbx(1'b1, `SPCG_OFS_IRQ_STAT, 32'h1);
                foreach (ofs[i]) begin
                    g[i] = (m == 3 && i == 2) ? 32'hffff_ffff : $urandom;
                    wbx(1'b1, ofs[i], g[i]);
                    wbx(1'b0, ofs[i], 32'h0);
                    chk("gate readback", g[i] & `SPCG_GATE_MASK, q);
                end
                sleepQ <= m[0];
                deepQ <= m[1];
                repeat (3) @(posedge mclk);
                #1;
                x = (a == 0 || m == 0) ? g[0] : (m == 1 ? g[1] : g[2]);
                chk("applied gates", comp(x), {22'h0, unitClkEn});
                t0 = ticks;
                repeat (4) @(posedge mclk);
                #1;
                for (int u = 0; u < 10; u++) runv[u] = ticks[u*8+:8] != t0[u*8+:8];
                chk("unit clocks", comp(x), {22'h0, runv});
                aq = 10'($urandom);
                @(posedge mclk);
                accReq <= aq;
                @(posedge mclk);
                #1;
                chk("unit fault", {22'h0, aq & ~comp(x)}, {22'h0, unitFault});
                @(posedge mclk);
                accReq <= 10'h0;
                repeat (2) @(posedge mclk);
                #1;
                chk("irq", 32'(a == 1 && (aq & ~comp(x)) != 0), {31'h0, irq});
            end
        end
        end_sim();
    end
endmodule : spcg_clock_gating_tb
